/* design/usbeq_pkg.sv */
// shared constants and types for the usb receiver gain control registers
`default_nettype none

package usbeq_pkg;

    // register offsets and reset value
    localparam logic [7:0] REG_DOWN_EQ   = 8'h20;
    localparam logic [7:0] REG_UP_EQ     = 8'h21;
    localparam logic [7:0] REG_LINK_CTRL = 8'h22;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // field positions inside the link control register
    localparam int COMPLIANCE_MODE_ACTIVE_BIT  = 7;
    localparam int LFPS_APPLY_BIT = 6;
    localparam int DEBOUNCE_BIT   = 5;
    localparam int DETECT_OFF_BIT = 4;
    localparam int PERIOD_LO_BIT  = 2;
    localparam int COMPL_LO_BIT   = 0;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS         = 1000;
    localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_US   = 200;
    localparam int US_PER_MS     = 1000;
    localparam int DET_MS_0      = 8;
    localparam int DET_MS_1      = 12;
    localparam int DET_MS_2      = 48;
    localparam int DET_MS_3      = 96;

    // default target address on the serial port
    localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h12;

    typedef enum logic [1:0] {
        USBEQ_CM_AUTO = 2'h0,
        USBEQ_CM_DOWN = 2'h1,
        USBEQ_CM_UP   = 2'h2,
        USBEQ_CM_OFF  = 2'h3
    } usbeq_compl_type;

    // serial target states, gray along the usual path
    typedef enum logic [3:0] {
        USBEQ_IDLE = 4'h0,
        USBEQ_ADDR = 4'h1,
        USBEQ_AACK = 4'h3,
        USBEQ_PTR  = 4'h2,
        USBEQ_PACK = 4'h6,
        USBEQ_WR   = 4'h7,
        USBEQ_WACK = 4'h5,
        USBEQ_RD   = 4'h4,
        USBEQ_RACK = 4'hc
    } usbeq_i2c_state_type;

    // two strap pins pick one of four gain steps
    function automatic logic [3:0] usbeq_strap_gain(input logic [1:0] strap);
        unique case (strap)
            2'h0: usbeq_strap_gain = 4'h0;
            2'h1: usbeq_strap_gain = 4'h4;
            2'h2: usbeq_strap_gain = 4'h8;
            2'h3: usbeq_strap_gain = 4'hc;
        endcase
    endfunction : usbeq_strap_gain

endpackage : usbeq_pkg

`default_nettype wire

/* design/usbeq_i2c_target.sv */
// serial register port: two-wire target with pointer, auto increment
`default_nettype none

module usbeq_i2c_target
    import usbeq_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = I2C_ADDR_DEFAULT
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // bus pins
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // register side
    output logic            wrStb,
    output logic [7:0]      regAddr,
    output logic [7:0]      wrData,
    input  wire logic [7:0] rdData
);

    typedef struct packed {
        logic [2:0]          scl;
        logic [2:0]          sda;
        usbeq_i2c_state_type st;
        logic [2:0]          bitCnt;
        logic [7:0]          shift;
        logic                ackPhase;
        logic [7:0]          ptr;
        logic                oe;
        logic                stb;
        logic [7:0]          data;
    } usbeq_i2c_type;

    usbeq_i2c_type q, d;
    logic          rise, fall, start, stop;
    logic [7:0]    inByte;

    // stage 0 feeds stage 1 only; edges come from stages 1 and 2
    assign rise   = q.scl[1] & ~q.scl[2];
    assign fall   = ~q.scl[1] & q.scl[2];
    assign start  = q.scl[1] & q.sda[2] & ~q.sda[1];
    assign stop   = q.scl[1] & ~q.sda[2] & q.sda[1];
    assign inByte = {q.shift[6:0], q.sda[1]};

    always_comb begin
        d        = q;
        d.scl    = {q.scl[1:0], sclIn};
        d.sda    = {q.sda[1:0], sdaIn};
        d.stb    = 1'b0;
        if (stop) begin
            d.st = USBEQ_IDLE;
            d.oe = 1'b0;
        end else if (start) begin
            d.st       = USBEQ_ADDR;
            d.bitCnt   = 3'h0;
            d.ackPhase = 1'b0;
            d.oe       = 1'b0;
        end else begin
            unique case (q.st)
                USBEQ_IDLE: begin
                    d.oe = 1'b0;
                end
                USBEQ_ADDR, USBEQ_PTR, USBEQ_WR: begin
                    if (rise) begin
                        d.shift  = inByte;
                        d.bitCnt = q.bitCnt + 3'h1;
                        if (q.bitCnt == 3'h7) begin
                            if (q.st == USBEQ_ADDR) begin
                                d.st = (inByte[7:1] == DEV_ADDR)
                                       ? USBEQ_AACK : USBEQ_IDLE;
                            end else if (q.st == USBEQ_PTR) begin
                                d.ptr = inByte;
                                d.st  = USBEQ_PACK;
                            end else begin
                                d.stb  = 1'b1;
                                d.data = inByte;
                                d.st   = USBEQ_WACK;
                            end
                        end
                    end
                end
                USBEQ_AACK, USBEQ_PACK, USBEQ_WACK: begin
                    if (fall && !q.ackPhase) begin
                        d.oe       = 1'b1;
                        d.ackPhase = 1'b1;
                    end else if (fall) begin
                        d.oe       = 1'b0;
                        d.ackPhase = 1'b0;
                        d.bitCnt   = 3'h0;
                        if (q.st == USBEQ_AACK && q.shift[0]) begin
                            d.st    = USBEQ_RD;
                            d.oe    = ~rdData[7];
                            d.shift = {rdData[6:0], 1'b0};
                        end else if (q.st == USBEQ_AACK) begin
                            d.st = USBEQ_PTR;
                        end else begin
                            if (q.st == USBEQ_WACK) begin
                                d.ptr = q.ptr + 8'h01;
                            end
                            d.st = USBEQ_WR;
                        end
                    end
                end
                USBEQ_RD: begin
                    if (fall && q.bitCnt == 3'h7) begin
                        d.oe       = 1'b0;
                        d.ackPhase = 1'b0;
                        d.st       = USBEQ_RACK;
                    end else if (fall) begin
                        d.oe     = ~q.shift[7];
                        d.shift  = {q.shift[6:0], 1'b0};
                        d.bitCnt = q.bitCnt + 3'h1;
                    end
                end
                USBEQ_RACK: begin
                    if (rise && q.sda[1]) begin
                        d.st = USBEQ_IDLE;
                    end else if (rise) begin
                        d.ptr      = q.ptr + 8'h01;
                        d.ackPhase = 1'b1;
                    end else if (fall && q.ackPhase) begin
                        d.ackPhase = 1'b0;
                        d.bitCnt   = 3'h0;
                        d.st       = USBEQ_RD;
                        d.oe       = ~rdData[7];
                        d.shift    = {rdData[6:0], 1'b0};
                    end
                end
                default: begin
                    d.st = USBEQ_IDLE;
                    d.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q       <= '0;
            q.scl   <= 3'h7;
            q.sda   <= 3'h7;
            q.st    <= USBEQ_IDLE;
        end else begin
            q <= d;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut  = 1'b0;
    assign sdaOe   = q.oe;
    assign wrStb   = q.stb;
    assign regAddr = q.ptr;
    assign wrData  = q.data;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_stop_release: assert property (stop |=> !sdaOe)
        else $error("data line still driven after stop");
    chk_write_pulse: assert property (wrStb |=> !wrStb)
        else $error("write strobe longer than one cycle");

endmodule : usbeq_i2c_target

`default_nettype wire

/* design/usbeq_ctrl_regs.sv */
// usb receiver gain, low power and compliance control registers
`default_nettype none

module usbeq_ctrl_regs
    import usbeq_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR   = I2C_ADDR_DEFAULT,
    parameter int         TICK_COUNT = US_CYCLES
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // serial register port
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // strap and override pins
    input  wire logic [1:0] downstreamGainStraps,
    input  wire logic [1:0] upstreamGainStraps,
    input  wire logic       gainSoftwareOverride,
    // link status
    input  wire logic       lowFreqSignalRx,
    input  wire logic       lowPowerState,
    input  wire logic       complianceFsmEntry,
    // receiver gains
    output logic [3:0]      rxAGainSelect,
    output logic [3:0]      rxBGainSelect,
    output logic [3:0]      upstreamRxGainSelect,
    // link control
    output logic            lowPowerExitGrant,
    output logic            rxDetectStrobe,
    output logic            complianceDownstream,
    output logic            complianceUpstream,
    output logic            complianceModeActive
);

    // the tick divider is seven bits wide, so larger counts cannot be served
    if (TICK_COUNT < 1 || TICK_COUNT > 127) begin : g_bad_tick
        $error("TICK_COUNT out of range");
    end

    localparam logic [6:0]  TICK_LAST = 7'(TICK_COUNT - 1);
    localparam logic [7:0]  DEB_TICKS = 8'(DEBOUNCE_US);
    localparam logic [16:0] DET_US_0  = 17'(DET_MS_0 * US_PER_MS);
    localparam logic [16:0] DET_US_1  = 17'(DET_MS_1 * US_PER_MS);
    localparam logic [16:0] DET_US_2  = 17'(DET_MS_2 * US_PER_MS);
    localparam logic [16:0] DET_US_3  = 17'(DET_MS_3 * US_PER_MS);

    typedef struct packed {
        logic [7:0]  s1;
        logic [7:0]  s2;
        logic [7:0]  downEq;
        logic [3:0]  upEq;
        logic [6:0]  ctrl;
        logic [6:0]  tickCnt;
        logic        tick;
        logic [7:0]  debCnt;
        logic [16:0] detCnt;
        logic [3:0]  gainA;
        logic [3:0]  gainB;
        logic [3:0]  gainUp;
        logic        exitGrant;
        logic        detStrobe;
        logic        cmDown;
        logic        cmUp;
        logic        cmActive;
    } usbeq_regs_type;

    usbeq_regs_type  q, d;
    logic            wrStb;
    logic [7:0]      regAddr, wrData, rdData;
    logic [1:0]      dsStrap, usStrap;
    logic            override, lfps, lowPower, fsmCm;
    logic            lfpsZero, detectOff;
    logic [16:0]     detLimit;
    usbeq_compl_type complSel;

    usbeq_i2c_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .sdaOut  (sdaOut),
        .sdaOe   (sdaOe),
        .wrStb   (wrStb),
        .regAddr (regAddr),
        .wrData  (wrData),
        .rdData  (rdData)
    );

    // pins are asynchronous: only the second stage is used
    assign {fsmCm, lowPower, lfps, override, usStrap, dsStrap} = q.s2;
    assign complSel  = usbeq_compl_type'(q.ctrl[COMPL_LO_BIT +: 2]);
    assign detectOff = q.ctrl[DETECT_OFF_BIT];
    assign lfpsZero  = lfps & ~q.ctrl[LFPS_APPLY_BIT];

    always_comb begin
        unique case (q.ctrl[PERIOD_LO_BIT +: 2])
            2'h0: detLimit = DET_US_0;
            2'h1: detLimit = DET_US_1;
            2'h2: detLimit = DET_US_2;
            2'h3: detLimit = DET_US_3;
        endcase
    end

    // read mux; unmapped pointers read zero
    always_comb begin
        unique case (regAddr)
            REG_DOWN_EQ:   rdData = q.downEq;
            REG_UP_EQ:     rdData = {4'h0, q.upEq};
            REG_LINK_CTRL: rdData = {q.cmActive, q.ctrl};
            default:       rdData = 8'h00;
        endcase
    end

    always_comb begin
        d      = q;
        d.s1   = {complianceFsmEntry, lowPowerState, lowFreqSignalRx,
                  gainSoftwareOverride, upstreamGainStraps, downstreamGainStraps};
        d.s2   = q.s1;
        // gain fields follow the straps until software takes over
        if (!override) begin
            d.downEq = {usbeq_strap_gain(dsStrap), usbeq_strap_gain(dsStrap)};
            d.upEq   = usbeq_strap_gain(usStrap);
        end else if (wrStb && regAddr == REG_DOWN_EQ) begin
            d.downEq = wrData;
        end else if (wrStb && regAddr == REG_UP_EQ) begin
            d.upEq = wrData[3:0];
        end
        if (wrStb && regAddr == REG_LINK_CTRL) begin
            d.ctrl = wrData[6:0];
        end
        // one microsecond tick keeps the long counters narrow
        d.tick    = (q.tickCnt == TICK_LAST);
        d.tickCnt = d.tick ? 7'h00 : q.tickCnt + 7'h01;
        // per-receiver gains, each four bits wide
        d.gainA  = lfpsZero ? 4'h0 : q.downEq[3:0];
        d.gainB  = lfpsZero ? 4'h0 : q.downEq[7:4];
        d.gainUp = lfpsZero ? 4'h0 : q.upEq;
        // debounce restarts whenever the signal drops
        if (!(lfps && lowPower)) begin
            d.debCnt = 8'h00;
        end else if (q.tick && q.debCnt < DEB_TICKS) begin
            d.debCnt = q.debCnt + 8'h01;
        end
        d.exitGrant = lowPower & lfps &
                      (~q.ctrl[DEBOUNCE_BIT] | (q.debCnt >= DEB_TICKS));
        // detection counter is held at zero in low power when switched off there
        d.detStrobe = 1'b0;
        if (lowPower && detectOff) begin
            d.detCnt = 17'h00000;
        end else if (q.tick) begin
            if (q.detCnt >= detLimit - 17'h00001) begin
                d.detCnt    = 17'h00000;
                d.detStrobe = 1'b1;
            end else begin
                d.detCnt = q.detCnt + 17'h00001;
            end
        end
        unique case (complSel)
            USBEQ_CM_AUTO: begin
                d.cmDown = 1'b0;
                d.cmUp   = 1'b0;
            end
            USBEQ_CM_DOWN: begin
                d.cmDown = 1'b1;
                d.cmUp   = 1'b0;
            end
            USBEQ_CM_UP: begin
                d.cmDown = 1'b0;
                d.cmUp   = 1'b1;
            end
            USBEQ_CM_OFF: begin
                d.cmDown = 1'b0;
                d.cmUp   = 1'b0;
            end
        endcase
        d.cmActive = (complSel == USBEQ_CM_DOWN) | (complSel == USBEQ_CM_UP) |
                     ((complSel == USBEQ_CM_AUTO) & fsmCm);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rxAGainSelect        = q.gainA;
    assign rxBGainSelect        = q.gainB;
    assign upstreamRxGainSelect = q.gainUp;
    assign lowPowerExitGrant    = q.exitGrant;
    assign rxDetectStrobe       = q.detStrobe;
    assign complianceDownstream = q.cmDown;
    assign complianceUpstream   = q.cmUp;
    assign complianceModeActive = q.cmActive;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence lfpsBlocked;
        lfps && !q.ctrl[LFPS_APPLY_BIT];
    endsequence

    chk_strap_mirror: assert property (!override |=> q.downEq[3:0] == usbeq_strap_gain($past(dsStrap)))
        else $error("downstream gain does not follow straps");
    chk_up_mirror: assert property (!override |=> q.upEq == usbeq_strap_gain($past(usStrap)))
        else $error("upstream gain does not follow straps");
    chk_lfps_zero: assert property (lfpsBlocked |=> rxAGainSelect == 4'h0 && rxBGainSelect == 4'h0)
        else $error("gain not zero during low frequency signal");
    chk_gain_apply: assert property (!lfpsZero |=> rxBGainSelect == $past(q.downEq[7:4]))
        else $error("receiver b gain not applied");
    chk_gain_a: assert property (!lfpsZero |=> rxAGainSelect == $past(q.downEq[3:0]))
        else $error("receiver a gain not applied");
    chk_force_down: assert property (complSel == USBEQ_CM_DOWN |=> complianceDownstream && complianceModeActive)
        else $error("forced downstream compliance not active");
    chk_cm_off: assert property (complSel == USBEQ_CM_OFF |=> !complianceModeActive)
        else $error("compliance active while disabled");
    chk_detect_off: assert property (lowPower && detectOff |=> !rxDetectStrobe)
        else $error("receiver detection while switched off");
    chk_debounce_hold: assert property (lowPower && lfps && q.ctrl[DEBOUNCE_BIT] && q.debCnt < DEB_TICKS |=> !lowPowerExitGrant)
        else $error("low power exit before debounce ends");
    chk_period_bound: assert property (q.detCnt < DET_US_3)
        else $error("detect counter beyond longest period");
    chk_reserved_zero: assert property (regAddr == REG_UP_EQ |-> rdData[7:4] == 4'h0)
        else $error("reserved nibble reads non zero");

endmodule : usbeq_ctrl_regs

`default_nettype wire

/* tb/usbeq_i2c_host.sv */
// two-wire host model that reaches the register port
`default_nettype none

module usbeq_i2c_host
    import usbeq_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // bus pins, open drain with pull-ups
    input  wire logic sdaLine,
    output logic      sclOut,
    output logic      sdaDrv
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclOut = 1'b1;
        sdaDrv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // a phase of ten clocks keeps well above the minimum of five
    task automatic bit_io(input logic b, output logic s);
        sdaDrv = b;
        tick(10);
        sclOut = 1'b1;
        tick(5);
        s = sdaLine;
        tick(5);
        sclOut = 1'b0;
        tick(2);
    endtask : bit_io

    task automatic byte_io(input logic [7:0] b, input logic ackIn,
                           output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(ackIn, ack);
    endtask : byte_io

    task automatic start();
        sdaDrv = 1'b1;
        sclOut = 1'b1;
        tick(10);
        sdaDrv = 1'b0;
        tick(10);
        sclOut = 1'b0;
        tick(2);
    endtask : start

    task automatic stop();
        sdaDrv = 1'b0;
        tick(10);
        sclOut = 1'b1;
        tick(10);
        sdaDrv = 1'b1;
        tick(10);
    endtask : stop

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                             input logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic [2:0] n;
        start();
        byte_io({dev, 1'b0}, 1'b1, r, n[0]);
        byte_io(a, 1'b1, r, n[1]);
        byte_io(d, 1'b1, r, n[2]);
        stop();
        nak = |n;
    endtask : write_reg

    // pointer set by a short write, then a fresh start for the read
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic [3:0] n;
        start();
        byte_io({I2C_ADDR_DEFAULT, 1'b0}, 1'b1, r, n[0]);
        byte_io(a, 1'b1, r, n[1]);
        stop();
        start();
        byte_io({I2C_ADDR_DEFAULT, 1'b1}, 1'b1, r, n[2]);
        byte_io(8'hff, 1'b1, d, n[3]);
        stop();
        nak = |n[2:0];
    endtask : read_reg
endmodule : usbeq_i2c_host

`default_nettype wire

/* tb/usb_path_eq_control_regs_bench.sv */
// self-checking bench for the usb gain control registers
`default_nettype none

module usb_path_eq_control_regs_bench
    import usbeq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys = 1'b0;
    logic       rst     = 1'b1;
    logic [1:0] dnStrap = 2'h0;
    logic [1:0] upStrap = 2'h0;
    logic       ovr = 1'b0, lfps = 1'b0, lowPwr = 1'b0, fsmCm = 1'b0;
    logic       sclOut, sdaDrv, sdaOut, sdaOe, sdaLine;
    logic [3:0] gA, gB, gU;
    logic       grant, det, cmDn, cmUp, cmAct, nak, seen;
    logic [7:0] rd;
    logic [3:0] tbl [4] = '{4'h0, 4'h4, 4'h8, 4'hc};
    int         err_count = 0, num_checks = 0, n;

    // released line reads high through the pull-up
    assign sdaLine = sdaDrv & (sdaOe ? sdaOut : 1'b1);

    usbeq_i2c_host host_u (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclOut(sclOut),
        .sdaDrv(sdaDrv));

    // one clock per tick keeps the long periods inside the run
    usbeq_ctrl_regs #(.TICK_COUNT(1)) dut_u (.clk_sys(clk_sys), .rst(rst), .sclIn(sclOut),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .downstreamGainStraps(dnStrap),
        .upstreamGainStraps(upStrap), .gainSoftwareOverride(ovr), .lowFreqSignalRx(lfps),
        .lowPowerState(lowPwr), .complianceFsmEntry(fsmCm), .rxAGainSelect(gA),
        .rxBGainSelect(gB), .upstreamRxGainSelect(gU), .lowPowerExitGrant(grant),
        .rxDetectStrobe(det), .complianceDownstream(cmDn), .complianceUpstream(cmUp),
        .complianceModeActive(cmAct));

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", w, e, s);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.write_reg(I2C_ADDR_DEFAULT, a, d, nak);
        tick(4);
    endtask : wr

    task automatic rdc(input string w, input logic [7:0] a, input logic [7:0] e);
        host_u.read_reg(a, rd, nak);
        check(w, {8'h0, rd}, {8'h0, e});
    endtask : rdc

    task automatic gains(input logic [3:0] a, input logic [3:0] b, input logic [3:0] u);
        check("rxA", {12'h0, gA}, {12'h0, a});
        check("rxB", {12'h0, gB}, {12'h0, b});
        check("rxUp", {12'h0, gU}, {12'h0, u});
    endtask : gains

    // bounded wait on the exit grant or the detect strobe
    task automatic wait_on(input logic useGrant, input int lim);
        n = 0;
        while ((useGrant ? grant : det) !== 1'b1) begin
            if (n >= lim) begin
                err_count++;
                complete_run();
            end
            tick(1);
            n++;
        end
    endtask : wait_on

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        tick(5);
        rst = 1'b0;
        tick(5);
        gains(4'h0, 4'h0, 4'h0);
        rdc("reg20", REG_DOWN_EQ, REG_RESET);
        rdc("reg21", REG_UP_EQ, REG_RESET);
        rdc("reg22", REG_LINK_CTRL, REG_RESET);
        rdc("unmapped", 8'h30, 8'h00);
        host_u.write_reg(7'h13, REG_LINK_CTRL, 8'h0c, nak);
        check("nack", {15'h0, nak}, 16'h1);
        for (int s = 0; s < 4; s++) begin
            dnStrap = 2'(s);
            upStrap = 2'(3 - s);
            tick(8);
            gains(tbl[s], tbl[s], tbl[3 - s]);
            rdc("strap20", REG_DOWN_EQ, {tbl[s], tbl[s]});
        end
        wr(REG_DOWN_EQ, 8'h5a);
        rdc("dropped", REG_DOWN_EQ, 8'hcc);
        rdc("strap21", REG_UP_EQ, 8'h00);
        ovr = 1'b1;
        tick(4);
        for (int i = 0; i < 16; i++) begin
            wr(REG_DOWN_EQ, {4'(i), 4'(15 - i)});
            gains(4'(15 - i), 4'(i), 4'h0);
        end
        wr(REG_DOWN_EQ, 8'hb3);
        wr(REG_UP_EQ, 8'hf9);
        gains(4'h3, 4'hb, 4'h9);
        rdc("sw20", REG_DOWN_EQ, 8'hb3);
        rdc("sw21", REG_UP_EQ, 8'h09);
        // gains forced to zero while low frequency signalling is seen
        lfps = 1'b1;
        tick(6);
        gains(4'h0, 4'h0, 4'h0);
        wr(REG_LINK_CTRL, 8'h40);
        gains(4'h3, 4'hb, 4'h9);
        lowPwr = 1'b1;
        wait_on(1'b1, 10);
        check("grantFast", {15'h0, grant}, 16'h1);
        lfps = 1'b0;
        tick(6);
        check("grantDrop", {15'h0, grant}, 16'h0);
        wr(REG_LINK_CTRL, 8'h60);
        lfps = 1'b1;
        tick(195);
        check("grantEarly", {15'h0, grant}, 16'h0);
        wait_on(1'b1, 20);
        check("grantLate", {15'h0, grant}, 16'h1);
        lfps = 1'b0;
        lowPwr = 1'b0;
        fsmCm = 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(REG_LINK_CTRL, 8'(m * 5));
            check("cmDown", {15'h0, cmDn}, {15'h0, m == 1});
            check("cmUp", {15'h0, cmUp}, {15'h0, m == 2});
            rdc("mode22", REG_LINK_CTRL, {m != 3, 3'h0, 2'(m), 2'(m)});
        end
        fsmCm = 1'b0;
        wr(REG_LINK_CTRL, 8'h00);
        check("cmIdle", {15'h0, cmAct}, 16'h0);
        wr(REG_LINK_CTRL, 8'hff);
        rdc("roBit", REG_LINK_CTRL, 8'h7f);
        wr(REG_LINK_CTRL, 8'h00);
        wait_on(1'b0, 9000);
        tick(1);
        wait_on(1'b0, 9000);
        check("gap8", 16'(n + 1), 16'd8000);
        wr(REG_LINK_CTRL, 8'h04);
        wait_on(1'b0, 13000);
        tick(1);
        wait_on(1'b0, 13000);
        check("gap12", 16'(n + 1), 16'd12000);
        lowPwr = 1'b1;
        wr(REG_LINK_CTRL, 8'h10);
        seen = 1'b0;
        repeat (8500) begin
            tick(1);
            seen = seen | det;
        end
        check("noDetect", {15'h0, seen}, 16'h0);
        complete_run();
    end
endmodule : usb_path_eq_control_regs_bench

`default_nettype wire
